// File: bench/rscs_assertions.sv
`timescale 1ns/1ps
module rscs_assertions
  import rscs_pkg::*;
#(parameter int NG = 16, parameter int SW = 8, parameter int NO = 12) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_master_reset_low,
  input wire logic [NG-1:0] i_gpio,
  input wire logic i_info_valid,
  input wire logic o_port_i2c,
  input wire logic o_slave_addr_bit_two,
  input wire logic [SW-1:0] o_cfg_index,
  input wire logic o_ee_search_req,
  input wire logic o_clk_en,
  input wire logic o_cal_start,
  input wire logic o_lock_req,
  input wire logic o_ready,
  input wire logic [NO-1:0] o_out_en,
  input wire logic [NG-1:0] o_gpio_oe,
  input wire logic [NG-1:0] o_startup_register_image
);
  wire mr = i_master_reset_low;
  wire [NG-1:0] img = o_startup_register_image;
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (i_srst);
  image_capture_a: assert property ($rose(mr) |=> img == $past(i_gpio))
    else $error("image not captured");
  // two quiet edges needed: the capture edge itself still shows the old image
  image_hold_a: assert property (mr && $past(mr) && $past(mr, 2) |-> $stable(img))
    else $error("image changed");
  port_decode_a: assert property ($rose(mr) |-> ##4 (o_port_i2c == $past(i_gpio[RSCS_PORT_PIN], 4)))
    else $error("port mode wrong");
  spi_addr_a: assert property ($rose(mr) ##4 !o_port_i2c |-> !o_slave_addr_bit_two)
    else $error("addr bit set in spi");
  spi_search_a: assert property ($rose(mr) ##4 !o_port_i2c |-> !o_ee_search_req [*8])
    else $error("eeprom search in spi");
  default_index_a: assert property ($rose(mr) && !i_info_valid |-> ##4 (o_cfg_index == SW'($past(i_gpio[3:0], 4))))
    else $error("default index wrong");
  cal_order_a: assert property (o_cal_start |-> o_clk_en ##1 !o_cal_start)
    else $error("cal start order");
  ready_order_a: assert property (o_ready |-> o_lock_req && o_clk_en)
    else $error("ready too early");
  outputs_off_a: assert property (o_out_en == '0 && o_gpio_oe == '0)
    else $error("output enabled");
endmodule : rscs_assertions

bind rscs_top rscs_assertions #(.NG(NG), .SW(SW), .NO(NO)) rscs_assertions_i (
  .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_master_reset_low(i_master_reset_low),
  .i_gpio(i_gpio), .i_info_valid(i_info_valid), .o_port_i2c(o_port_i2c),
  .o_slave_addr_bit_two(o_slave_addr_bit_two), .o_cfg_index(o_cfg_index),
  .o_ee_search_req(o_ee_search_req), .o_clk_en(o_clk_en), .o_cal_start(o_cal_start),
  .o_lock_req(o_lock_req), .o_ready(o_ready), .o_out_en(o_out_en), .o_gpio_oe(o_gpio_oe),
  .o_startup_register_image(o_startup_register_image));

// File: bench/rscs_board.sv
`timescale 1ns/1ps
module rscs_board (
  input wire logic i_master_reset_low,
  input wire logic [15:0] i_drive,
  output logic [15:0] o_gpio
);
  // pin 8 pulled high while reset is low; straps keep clear of test-access pins
  assign o_gpio = i_master_reset_low ? i_drive : (i_drive | 16'h0100);
endmodule : rscs_board

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import rscs_pkg::*;
  logic clk = 0, srst = 1, mr = 0, iv = 0;
  logic [15:0] strap = 16'hFFFF, gpio, sel = 0, ee = 0, adr = 0, oe, img;
  // bit 13 loop locked, bit 2 eeprom search finished
  logic [13:0] x = 14'h2004;
  logic [4:0] cnt = 5'h00;
  logic pi2c, ab, sreq, skip, cal, rdy, udef, oreq, gf, rg;
  logic [7:0] idx;
  logic [11:0] oen;
  int bad_count = 0, checked = 0, cyc = 0, n = 0, k = 0;

  rscs_board rscs_board_i (.i_master_reset_low(mr), .i_drive(strap), .o_gpio(gpio));
  rscs_top rscs_top_i (
    .i_sys_clk(clk), .i_srst(srst), .i_master_reset_low(mr), .i_gpio(gpio),
    .i_info_valid(iv), .i_info_sel_mask(sel), .i_info_ee_mask(ee), .i_info_addr_mask(adr),
    .i_otp_cfg_count(cnt), .i_otp_done(x[0]), .i_otp_csum_ok(x[1]), .i_ee_done(x[2]),
    .i_ee_cfg_valid(x[3]), .i_ee_port_i2c(x[4]), .i_ee_addr_bit(x[5]), .i_otp_port_valid(x[6]),
    .i_otp_port_i2c(x[7]), .i_otp_addr_bit(x[8]), .i_wr_port_en(x[9]), .i_wr_port_i2c(x[10]),
    .i_wr_addr_en(x[11]), .i_wr_addr_bit(x[12]), .i_pll_locked(x[13]), .o_port_i2c(pi2c),
    .o_slave_addr_bit_two(ab), .o_cfg_index(idx), .o_otp_load_req(oreq), .o_ee_search_req(sreq),
    .o_ee_skip(skip), .o_reg_en(rg), .o_clk_en(), .o_cal_start(cal), .o_lock_req(), .o_ready(rdy),
    .o_use_defaults(udef), .o_guard_fault(gf), .o_out_en(oen), .o_gpio_oe(oe),
    .o_startup_register_image(img));

  initial begin
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // straps settle before reset, then released; outputs settled six cycles on
  task automatic boot(input logic [15:0] p, s, e, a);
    strap = p;
    sel = s;
    ee = e;
    adr = a;
    iv = |{s, e, a};
    mr = 0;
    repeat (3) @(negedge clk);
    mr = 1;
    repeat (6) @(negedge clk);
  endtask : boot

  // one-cycle overwrite strobe at x[b], value at x[b+1]
  task automatic wr(input int b, input logic v);
    x[b] = 1;
    x[b+1] = v;
    @(negedge clk);
    x[b] = 0;
    repeat (3) @(negedge clk);
  endtask : wr

  task automatic fin();
    n++;
    $display("test %0d done", n);
  endtask : fin

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (3) @(negedge clk);
    srst = 0;
    boot(16'hFFFF, 0, 0, 0);
    chk(pi2c, 1);
    chk(idx, 8'h0F);
    chk(ab, 0);
    chk(skip, 0);
    chk(img, 16'hFFFF);
    chk(oen, 0);
    chk(oe, 0);
    chk(udef, 1);
    chk(rg, 1);
    chk(cal, 1);
    while (rdy !== 1'b1 && k < 400) begin
      @(negedge clk);
      k++;
    end
    chk(k, RSCS_CAL_CYC + 2);
    chk(rdy, 1);
    fin();
    boot(16'hFDFF, 0, 0, 16'h0020);
    chk(pi2c, 0);
    chk(ab, 0);
    chk(skip, 1);
    fin();
    // scattered select pins 8,6,5,2; address pins 7 and 5; two eeprom-disable pins
    boot(16'h0B60, 16'h0164, 16'h0C00, 16'h00A0);
    chk(idx, 8'h0E);
    chk(ab, 0);
    chk(skip, 1);
    fin();
    boot(16'hFFFE, 16'h0003, 0, 0);
    chk(idx, 8'h02);
    fin();
    boot(16'h2BFF, 16'h3F00, 0, 16'h0080);
    chk(idx, 8'h2B);
    chk(ab, 1);
    fin();
    wr(11, 0);
    chk(ab, 0);
    wr(9, 0);
    chk(pi2c, 0);
    strap = 16'h0000;
    repeat (3) @(negedge clk);
    chk(img, 16'h2BFF);
    chk(gf, 0);
    // stored configs present: first load fails its checksum, second applies spi and address bit
    cnt = 5'h03;
    x[6] = 1;
    x[8] = 1;
    boot(16'hFFFF, 0, 0, 0);
    chk(oreq, 1);
    wr(0, 0);
    chk(oreq, 0);
    chk(udef, 1);
    chk(pi2c, 1);
    boot(16'hFFFF, 0, 0, 0);
    wr(0, 1);
    chk(udef, 0);
    chk(pi2c, 0);
    chk(ab, 1);
    chk(skip, 1);
    x[6] = 0;
    cnt = 5'h00;
    fin();
    boot(16'hFFFF, 0, 0, 0);
    chk(pi2c, 1);
    fin();
    report_and_stop();
  end
endmodule : tb_top

// File: rtl/rscs_decode.sv
`timescale 1ns/1ps
module rscs_decode
  import rscs_pkg::*;
#(
  parameter int NG = RSCS_NUM_GPIO,
  parameter int SW = RSCS_SEL_MAX
) (
  rscs_strap_if.dec s
);
  // gather masked pins low to high so the lowest pin lands in the lsb
  always_comb begin
    logic [SW-1:0] w;
    logic [3:0] n;
    logic a;
    w = '0;
    n = '0;
    a = 1'b0;
    for (int i = 0; i < NG; i++) begin
      if (s.sel_mask[i] && (n < 4'(SW))) begin
        w[n[2:0]] = s.pins[i];
        n = n + 4'h1;
      end
      if (s.addr_mask[i]) begin
        a = s.pins[i];
      end
    end
    s.sel_word = w;
    s.sel_count = n;
    s.addr_bit = a;
    s.ee_dis = |(s.pins & s.ee_mask);
  end
endmodule : rscs_decode

// File: rtl/rscs_pkg.sv
// What this block does
// - capture every gpio pin when master reset is released; build initial setup
// - captured pin 9 picks main serial port: low spi, high i2c
// - no select pins designated: pins 3..0 form index, floating gives 15
// - select pins may be scattered; lowest pin is lsb, highest is msb
// - fewer than four select pins fill low bits, upper bits zero
// - more than four select pins concatenate into a wider selection word
// - info record may move selection to any set of up to eight pins
// - index picks stored configuration; ignored when no configurations are stored
// - designated address pin gives slave address bit two, else zero
// - several address pins designated: only the highest-numbered one counts
// - address bit two selection ignored when port strapped to spi
// - high on an eeprom-disable pin stops eeprom reads at start-up
// - no eeprom-disable pin designated: eeprom search attempted whenever port is i2c
// - several eeprom-disable pins are ored together
// - strap-derived port and address settings stay writable by later serial-port accesses
// - address and port setup may be replaced by later loaded configuration
// - with nothing loaded, defaults disable clock outputs, gpios are inputs
// - reset sequence enables regulators with strap decode, loads stored setup, clocks, calibrates, locks loop
// - initial setup comes from straps, stored config, eeprom and defaults
// - pin roles come from the info record; unprogrammed parts use defaults
// - stored configuration failing checksum is skipped, registers stay default
// - eeprom search skipped whenever port is spi when the eeprom step starts
package rscs_pkg;
  localparam int RSCS_NUM_GPIO = 16;
  localparam int RSCS_SEL_MAX = 8;
  localparam int RSCS_IDX_W = 4;
  localparam int RSCS_PORT_PIN = 9;
  localparam int RSCS_GUARD_PIN = 8;
  localparam logic [RSCS_NUM_GPIO-1:0] RSCS_DEF_SEL_MASK = 16'h000F;
  localparam logic RSCS_PORT_SPI = 1'h0;
  localparam logic RSCS_PORT_I2C = 1'h1;
  localparam int RSCS_NUM_OUT = 12;
  localparam logic [RSCS_NUM_OUT-1:0] RSCS_OUT_EN_RST = 12'h000;
  localparam logic [RSCS_NUM_GPIO-1:0] RSCS_GPIO_OE_RST = 16'h0000;
  localparam int RSCS_CFG_W = 32;
  localparam int RSCS_CAL_TIME_NS = 1000;
  localparam int RSCS_CLK_NS = 8;
  localparam int RSCS_CAL_CYC = (RSCS_CAL_TIME_NS + RSCS_CLK_NS - 1) / RSCS_CLK_NS;
  localparam logic [7:0] RSCS_CAL_CYC_T = 8'(RSCS_CAL_CYC);

  typedef enum logic [8:0] {
    RSCS_ST_RESET = 9'h001,
    RSCS_ST_LOAD = 9'h002,
    RSCS_ST_OTP = 9'h004,
    RSCS_ST_EEPROM = 9'h008,
    RSCS_ST_REG = 9'h010,
    RSCS_ST_CLK = 9'h020,
    RSCS_ST_CAL = 9'h040,
    RSCS_ST_LOCK = 9'h080,
    RSCS_ST_RUN = 9'h100
  } rscs_state_e;
endpackage : rscs_pkg

// File: rtl/rscs_strap_if.sv
`timescale 1ns/1ps
interface rscs_strap_if #(parameter int NG = 16, parameter int SW = 8);
  logic [NG-1:0] pins;
  logic [NG-1:0] sel_mask;
  logic [NG-1:0] ee_mask;
  logic [NG-1:0] addr_mask;
  logic [SW-1:0] sel_word;
  logic [3:0] sel_count;
  logic ee_dis;
  logic addr_bit;
  modport dec (input pins, sel_mask, ee_mask, addr_mask, output sel_word, sel_count, ee_dis, addr_bit);
  modport ctl (output pins, sel_mask, ee_mask, addr_mask, input sel_word, sel_count, ee_dis, addr_bit);
endinterface : rscs_strap_if

// File: rtl/rscs_top.sv
`timescale 1ns/1ps
module rscs_top
  import rscs_pkg::*;
#(
  parameter int NG = RSCS_NUM_GPIO,
  parameter int SW = RSCS_SEL_MAX,
  parameter int NO = RSCS_NUM_OUT
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_master_reset_low,
  input wire logic [NG-1:0] i_gpio,
  input wire logic i_info_valid,
  input wire logic [NG-1:0] i_info_sel_mask,
  input wire logic [NG-1:0] i_info_ee_mask,
  input wire logic [NG-1:0] i_info_addr_mask,
  input wire logic [4:0] i_otp_cfg_count,
  input wire logic i_otp_done,
  input wire logic i_otp_csum_ok,
  input wire logic i_ee_done,
  input wire logic i_ee_cfg_valid,
  input wire logic i_ee_port_i2c,
  input wire logic i_ee_addr_bit,
  input wire logic i_otp_port_valid,
  input wire logic i_otp_port_i2c,
  input wire logic i_otp_addr_bit,
  input wire logic i_wr_port_en,
  input wire logic i_wr_port_i2c,
  input wire logic i_wr_addr_en,
  input wire logic i_wr_addr_bit,
  input wire logic i_pll_locked,
  output logic o_port_i2c,
  output logic o_slave_addr_bit_two,
  output logic [SW-1:0] o_cfg_index,
  output logic o_otp_load_req,
  output logic o_ee_search_req,
  output logic o_ee_skip,
  output logic o_reg_en,
  output logic o_clk_en,
  output logic o_cal_start,
  output logic o_lock_req,
  output logic o_ready,
  output logic o_use_defaults,
  output logic o_guard_fault,
  output logic [NO-1:0] o_out_en,
  output logic [NG-1:0] o_gpio_oe,
  output logic [NG-1:0] o_startup_register_image
);
  typedef struct packed {
    rscs_state_e st;
    logic mr_q;
    logic [NG-1:0] cap;
    logic cap_valid;
    logic port_i2c;
    logic addr_bit;
    logic [SW-1:0] idx;
    logic ee_dis;
    logic otp_req;
    logic ee_req;
    logic ee_skip;
    logic reg_en;
    logic clk_en;
    logic cal_start;
    logic lock_req;
    logic ready;
    logic use_def;
    logic guard_fault;
    logic [7:0] cnt;
  } rscs_state_s;

  rscs_state_s r_q;
  rscs_state_s r_d;

  rscs_strap_if #(.NG(NG), .SW(SW)) s_if ();

  rscs_decode #(.NG(NG), .SW(SW)) u_dec (
    .s(s_if)
  );

  // roles come from the info record; a part without one keeps pins 3..0
  assign s_if.pins = r_q.cap;
  assign s_if.sel_mask = (i_info_valid && (i_info_sel_mask != '0)) ? i_info_sel_mask : NG'(RSCS_DEF_SEL_MASK);
  assign s_if.ee_mask = i_info_valid ? i_info_ee_mask : '0;
  assign s_if.addr_mask = i_info_valid ? i_info_addr_mask : '0;

  always_comb begin
    r_d = r_q;
    r_d.mr_q = i_master_reset_low;
    r_d.cal_start = 1'b0;
    // guard pin watched while master reset is low; flags a bad board
    if (!i_master_reset_low && !i_gpio[RSCS_GUARD_PIN]) begin
      r_d.guard_fault = 1'b1;
    end
    if (!i_master_reset_low) begin
      r_d.st = RSCS_ST_RESET;
      r_d.cap_valid = 1'b0;
      r_d.otp_req = 1'b0;
      r_d.ee_req = 1'b0;
      r_d.reg_en = 1'b0;
      r_d.clk_en = 1'b0;
      r_d.lock_req = 1'b0;
      r_d.ready = 1'b0;
      r_d.use_def = 1'b1;
      r_d.ee_skip = 1'b0;
    end else if (!r_q.mr_q) begin
      // rising edge of master reset: take every pin once, hold through the next reset until the next release
      r_d.cap = i_gpio;
      r_d.cap_valid = 1'b1;
      r_d.st = RSCS_ST_LOAD;
    end else begin
      case (r_q.st)
        RSCS_ST_RESET: begin
          r_d.st = RSCS_ST_RESET;
        end
        RSCS_ST_LOAD: begin
          // decode waits one cycle so the captured pins are stable
          r_d.port_i2c = r_q.cap[RSCS_PORT_PIN];
          r_d.addr_bit = r_q.cap[RSCS_PORT_PIN] ? s_if.addr_bit : 1'b0;
          r_d.idx = s_if.sel_word;
          r_d.ee_dis = s_if.ee_dis;
          r_d.reg_en = 1'b1;
          r_d.use_def = 1'b1;
          if (i_otp_cfg_count != 5'h00) begin
            r_d.otp_req = 1'b1;
            r_d.st = RSCS_ST_OTP;
          end else begin
            r_d.st = RSCS_ST_EEPROM;
          end
        end
        RSCS_ST_OTP: begin
          if (i_otp_done) begin
            r_d.otp_req = 1'b0;
            if (i_otp_csum_ok) begin
              r_d.use_def = 1'b0;
              if (i_otp_port_valid) begin
                r_d.port_i2c = i_otp_port_i2c;
                r_d.addr_bit = i_otp_addr_bit;
              end
            end
            // bad checksum: nothing applied, defaults remain
            r_d.st = RSCS_ST_EEPROM;
          end
        end
        RSCS_ST_EEPROM: begin
          // no i2c master pins in spi mode, so the search cannot run
          if (r_q.ee_dis || !r_q.port_i2c) begin
            r_d.ee_skip = 1'b1;
            r_d.st = RSCS_ST_REG;
          end else if (!r_q.ee_req) begin
            r_d.ee_req = 1'b1;
            r_d.ee_skip = 1'b0;
          end else if (i_ee_done) begin
            r_d.ee_req = 1'b0;
            if (i_ee_cfg_valid) begin
              r_d.use_def = 1'b0;
              r_d.port_i2c = i_ee_port_i2c;
              r_d.addr_bit = i_ee_addr_bit;
            end
            r_d.st = RSCS_ST_REG;
          end
        end
        RSCS_ST_REG: begin
          r_d.clk_en = 1'b1;
          r_d.st = RSCS_ST_CLK;
        end
        RSCS_ST_CLK: begin
          r_d.cal_start = 1'b1;
          r_d.cnt = RSCS_CAL_CYC_T;
          r_d.st = RSCS_ST_CAL;
        end
        RSCS_ST_CAL: begin
          if (r_q.cnt == 8'h00) begin
            r_d.lock_req = 1'b1;
            r_d.st = RSCS_ST_LOCK;
          end else begin
            r_d.cnt = r_q.cnt - 8'h01;
          end
        end
        RSCS_ST_LOCK: begin
          if (i_pll_locked) begin
            r_d.ready = 1'b1;
            r_d.st = RSCS_ST_RUN;
          end
        end
        RSCS_ST_RUN: begin
          r_d.st = RSCS_ST_RUN;
        end
        default: begin
          r_d.st = RSCS_ST_RESET;
        end
      endcase
      // serial-port writes override strap results at any time after capture
      if (r_q.cap_valid && i_wr_port_en) begin
        r_d.port_i2c = i_wr_port_i2c;
      end
      if (r_q.cap_valid && i_wr_addr_en) begin
        r_d.addr_bit = i_wr_addr_bit;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      r_q <= '0;
      r_q.st <= RSCS_ST_RESET;
      r_q.port_i2c <= RSCS_PORT_I2C;
      r_q.use_def <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs and gpio directions: defaults are off/input
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_port_i2c <= RSCS_PORT_I2C;
      o_slave_addr_bit_two <= 1'b0;
      o_cfg_index <= '0;
      o_otp_load_req <= 1'b0;
      o_ee_search_req <= 1'b0;
      o_ee_skip <= 1'b0;
      o_reg_en <= 1'b0;
      o_clk_en <= 1'b0;
      o_cal_start <= 1'b0;
      o_lock_req <= 1'b0;
      o_ready <= 1'b0;
      o_use_defaults <= 1'b1;
      o_guard_fault <= 1'b0;
      o_out_en <= NO'(RSCS_OUT_EN_RST);
      o_gpio_oe <= NG'(RSCS_GPIO_OE_RST);
      o_startup_register_image <= '0;
    end else begin
      o_port_i2c <= r_d.port_i2c;
      o_slave_addr_bit_two <= r_d.addr_bit;
      o_cfg_index <= r_d.idx;
      o_otp_load_req <= r_d.otp_req;
      o_ee_search_req <= r_d.ee_req;
      o_ee_skip <= r_d.ee_skip;
      o_reg_en <= r_d.reg_en;
      o_clk_en <= r_d.clk_en;
      o_cal_start <= r_d.cal_start;
      o_lock_req <= r_d.lock_req;
      o_ready <= r_d.ready;
      o_use_defaults <= r_d.use_def;
      o_guard_fault <= r_d.guard_fault;
      o_out_en <= NO'(RSCS_OUT_EN_RST);
      o_gpio_oe <= NG'(RSCS_GPIO_OE_RST);
      o_startup_register_image <= r_d.cap;
    end
  end
endmodule : rscs_top
